// >>> core/emc_ctrl.sv
// Purpose: decodes master control two and the multiframe alignment word, and
//          builds line timeslot 16 and the alarm / pin behaviour they select
// Assumes: one serial bit per SYS_CLK edge on which BIT_STB is high; FRAME_SYNC
//          marks bit 0 of channel 0 of every stream frame
// Notes:   line bytes are produced in parallel per timeslot for the line coder;
//          a word on channel 31 is staged and applied on the same edge, so new
//          settings govern the whole next frame and never split one;
//          the 8 kHz pin is high from frame start to slot 16, not an even duty
`timescale 1ns/100ps
module emc_ctrl
   import emc_pkg::*;
#(
   parameter int CH_W = 5
)(
   input  wire logic       SYS_CLK,
   input  wire logic       RST,
   input  wire logic       BIT_STB,
   input  wire logic       FRAME_SYNC,
   input  wire logic       control_in_stream_a,
   input  wire logic       control_in_stream_b,
   input  wire logic       serial_data_in_stream,
   input  wire logic [7:0] RX_SLOT_DATA,
   input  wire logic       RX_SLOT_VALID,
   input  wire logic [4:0] RX_SLOT_NUM,
   input  wire logic       RX_FRAME_LOCK,
   input  wire logic       RX_FRAME_PULSE,
   output logic [7:0]      TX_SLOT_DATA,
   output logic            TX_SLOT_VALID,
   output logic [4:0]      TX_SLOT_NUM,
   output logic [3:0]      TX_FRAME_NUM,
   output logic [7:0]      SLOT16_RX_DATA,
   output logic            SLOT16_RX_VALID,
   output logic            COMMON_MODE,
   output logic            SIG_CTRL_VALID,
   output logic [7:0]      SIG_CTRL_WORD,
   output logic            recovered_frame_clock_pin_o,
   output logic            recovered_frame_clock_pin_oe_n,
   output logic            general_output_pin
);
   import emc_pkg::*;

   // shift and bit counters
   logic [7:0]      sh_a_reg, sh_a_next;
   logic [7:0]      sh_b_reg, sh_b_next;
   logic [7:0]      sh_d_reg, sh_d_next;
   logic [2:0]      bit_reg, bit_next;
   logic [CH_W-1:0] ch_reg, ch_next;
   logic [3:0]      frm_reg, frm_next;
   // staged words (captured) and applied words
   logic [7:0]      mc2_stage_reg, mc2_stage_next;
   logic [7:0]      mf_stage_reg, mf_stage_next;
   logic [7:0]      master_control_two_reg, master_control_two_next;
   logic [7:0]      tx_multiframe_align_word_reg, tx_multiframe_align_word_next;
   // one ABCD word per frame of the multiframe; entry 0 is never read
   logic [7:0]      cas_reg [FRAMES];
   logic [7:0]      cas_next [FRAMES];
   logic [7:0]      tx_data_reg, tx_data_next;
   logic            tx_valid_reg, tx_valid_next;
   logic [4:0]      tx_num_reg, tx_num_next;
   logic [7:0]      s16_reg, s16_next;
   logic            s16_valid_reg, s16_valid_next;
   logic [7:0]      sig_reg, sig_next;
   logic            sig_valid_reg, sig_valid_next;
   logic            rclk_reg, rclk_next;

   logic            ch_done;
   logic [7:0]      sa_full, sb_full, sd_full;
   logic [4:0]      ch5;

   // applied master word fields
   logic            common_signalling_select;
   logic            recovered_clock_out_enable;
   logic            transmit_all_ones_alarm;
   logic            transmit_sig_slot_all_ones;
   logic            general_output_level;

   typedef enum logic [1:0] {
      EMC_IDLE = 2'b00,
      EMC_RUN  = 2'b01
   } emc_state_t;
   emc_state_t state_reg, state_next;

   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
      shift_in = {s[6:0], b};
   endfunction

   // timeslot 16 content for the frame being sent
   function automatic logic [7:0] slot16_byte(input logic [3:0] f, input logic [7:0] mf,
                                              input logic [7:0] cas_w);
      if (f == 4'h0)
         slot16_byte = mf;
      else
         slot16_byte = cas_w;
   endfunction

   // final line byte: alarms override whatever the slot would carry
   function automatic logic [7:0] line_byte(input logic [4:0] ch, input logic [7:0] base,
                                            input logic all_ones, input logic slot_ones);
      line_byte = base;
      if (ch == CH_SIG_SLOT && slot_ones)
         line_byte = ALL_ONES;
      if (all_ones)
         line_byte = ALL_ONES;
   endfunction

   // stream b channels that carry ABCD words in associated mode
   function automatic logic cas_channel(input logic [4:0] ch);
      cas_channel = (ch != 5'h00) && (ch < CH_SIG_SLOT);
   endfunction

   assign ch_done = BIT_STB && (bit_reg == 3'h7);
   assign sa_full = shift_in(sh_a_reg, control_in_stream_a);
   assign sb_full = shift_in(sh_b_reg, control_in_stream_b);
   assign sd_full = shift_in(sh_d_reg, serial_data_in_stream);
   assign ch5     = 5'(ch_reg);

   // field decode of the applied master word
   assign common_signalling_select   = master_control_two_reg[BIT_COMMON_SEL];
   assign recovered_clock_out_enable = master_control_two_reg[BIT_RCLK_EN];
   assign transmit_all_ones_alarm    = master_control_two_reg[BIT_ALL_ONES];
   assign transmit_sig_slot_all_ones = master_control_two_reg[BIT_SLOT_ONES];
   assign general_output_level       = master_control_two_reg[BIT_GEN_OUT];

   always_comb begin
      state_next = state_reg;
      sh_a_next  = sh_a_reg;
      sh_b_next  = sh_b_reg;
      sh_d_next  = sh_d_reg;
      bit_next   = bit_reg;
      ch_next    = ch_reg;
      frm_next   = frm_reg;
      mc2_stage_next = mc2_stage_reg;
      mf_stage_next  = mf_stage_reg;
      master_control_two_next       = master_control_two_reg;
      tx_multiframe_align_word_next = tx_multiframe_align_word_reg;
      cas_next       = cas_reg;
      tx_data_next   = tx_data_reg;
      tx_valid_next  = 1'b0;
      tx_num_next    = tx_num_reg;
      sig_next       = sig_reg;
      sig_valid_next = 1'b0;
      case (state_reg)
         EMC_IDLE: begin
            if (FRAME_SYNC && BIT_STB) begin
               state_next = EMC_RUN;
               sh_a_next  = {7'h00, control_in_stream_a};
               sh_b_next  = {7'h00, control_in_stream_b};
               sh_d_next  = {7'h00, serial_data_in_stream};
               bit_next   = 3'h1;
               ch_next    = '0;
            end
         end
         EMC_RUN: begin
            if (BIT_STB) begin
               sh_a_next = sa_full;
               sh_b_next = sb_full;
               sh_d_next = sd_full;
               bit_next  = bit_reg + 3'h1;
               if (FRAME_SYNC) begin
                  // realign on every frame mark
                  sh_a_next = {7'h00, control_in_stream_a};
                  sh_b_next = {7'h00, control_in_stream_b};
                  sh_d_next = {7'h00, serial_data_in_stream};
                  bit_next  = 3'h1;
                  ch_next   = '0;
               end else if (ch_done) begin
                  // host places words on these channels
                  if (ch5 == CH_MASTER_TWO)
                     mc2_stage_next = sa_full;
                  if (ch5 == CH_MF_WORD)
                     mf_stage_next = sb_full;
                  if (ch5 == CH_SIG_CTRL && master_control_two_reg[BIT_COMMON_SEL]) begin
                     sig_next       = sa_full;
                     sig_valid_next = 1'b1;
                  end
                  // associated mode channels 1..15 carry ABCD; ignored in common mode
                  if (!common_signalling_select && cas_channel(ch5))
                     cas_next[ch5[3:0]] = sb_full;
                  // parallel line byte for this timeslot
                  tx_valid_next = 1'b1;
                  tx_num_next   = ch5;
                  tx_data_next  = sd_full;
                  if (ch5 == CH_SIG_SLOT && !common_signalling_select)
                     tx_data_next = slot16_byte(frm_reg, tx_multiframe_align_word_reg,
                                                cas_reg[frm_reg]);
                  // common mode keeps the stream byte in slot 16
                  tx_data_next = line_byte(ch5, tx_data_next, transmit_all_ones_alarm,
                                           transmit_sig_slot_all_ones);
                  ch_next = ch_reg + CH_W'(1);
                  if (ch5 == 5'(CH_COUNT - 1)) begin
                     // frame boundary: apply staged words
                     // take the staged value of this very edge, so a word sent
                     // on channel 31 rules the frame that starts next
                     master_control_two_next       = mc2_stage_next;
                     tx_multiframe_align_word_next = mf_stage_next;
                     frm_next = frm_reg + 4'h1;
                  end
               end
            end
         end
         default: state_next = EMC_IDLE;
      endcase
   end

   // receive side: slot 16 to output stream in common mode; 8 kHz clock
   always_comb begin
      s16_next       = s16_reg;
      s16_valid_next = 1'b0;
      rclk_next      = rclk_reg;
      if (RX_SLOT_VALID && RX_SLOT_NUM == CH_SIG_SLOT && master_control_two_reg[BIT_COMMON_SEL]) begin
         s16_next       = RX_SLOT_DATA;
         s16_valid_next = 1'b1;
      end
      // set on the frame pulse, cleared after slot 16: one cycle per received frame gives 8 kHz; only meaningful while locked
      // the level runs on while floating, so enabling the pin shows no glitch
      if (!RX_FRAME_LOCK)
         rclk_next = 1'b0;
      else if (RX_FRAME_PULSE)
         rclk_next = 1'b1;
      else if (RX_SLOT_VALID && RX_SLOT_NUM == CH_SIG_SLOT)
         rclk_next = 1'b0;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_reg     <= EMC_IDLE;
         sh_a_reg      <= '0;
         sh_b_reg      <= '0;
         sh_d_reg      <= '0;
         bit_reg       <= '0;
         ch_reg        <= '0;
         frm_reg       <= '0;
         mc2_stage_reg <= MASTER_TWO_RESET;
         mf_stage_reg  <= MF_WORD_RESET;
         master_control_two_reg       <= MASTER_TWO_RESET;
         tx_multiframe_align_word_reg <= MF_WORD_RESET;
         for (int i = 0; i < FRAMES; i++)
            cas_reg[i] <= IDLE_SIG;
         tx_data_reg   <= '0;
         tx_valid_reg  <= 1'b0;
         tx_num_reg    <= '0;
         s16_reg       <= '0;
         s16_valid_reg <= 1'b0;
         sig_reg       <= '0;
         sig_valid_reg <= 1'b0;
         rclk_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         sh_a_reg      <= sh_a_next;
         sh_b_reg      <= sh_b_next;
         sh_d_reg      <= sh_d_next;
         bit_reg       <= bit_next;
         ch_reg        <= ch_next;
         frm_reg       <= frm_next;
         mc2_stage_reg <= mc2_stage_next;
         mf_stage_reg  <= mf_stage_next;
         master_control_two_reg       <= master_control_two_next;
         tx_multiframe_align_word_reg <= tx_multiframe_align_word_next;
         cas_reg       <= cas_next;
         tx_data_reg   <= tx_data_next;
         tx_valid_reg  <= tx_valid_next;
         tx_num_reg    <= tx_num_next;
         s16_reg       <= s16_next;
         s16_valid_reg <= s16_valid_next;
         sig_reg       <= sig_next;
         sig_valid_reg <= sig_valid_next;
         rclk_reg      <= rclk_next;
      end
   end

   assign TX_SLOT_DATA    = tx_data_reg;
   assign TX_SLOT_VALID   = tx_valid_reg;
   assign TX_SLOT_NUM     = tx_num_reg;
   assign TX_FRAME_NUM    = frm_reg;
   assign SLOT16_RX_DATA  = s16_reg;
   assign SLOT16_RX_VALID = s16_valid_reg;
   assign COMMON_MODE     = common_signalling_select;
   assign SIG_CTRL_WORD   = sig_reg;
   assign SIG_CTRL_VALID  = sig_valid_reg;
   // bits 7 and 6 are host-held constants; nothing here depends on them
   assign recovered_frame_clock_pin_o    = rclk_reg;
   assign recovered_frame_clock_pin_oe_n = ~recovered_clock_out_enable;
   assign general_output_pin             = general_output_level;
endmodule // emc_ctrl

// >>> inc/emc_pkg.sv
// Purpose: constants for the master control two / multiframe word block
// Assumes: 2048 kbit/s streams, 32 channels of 8 bits, 16 frames per multiframe
// Notes:   bit positions are msb-first within a channel
package emc_pkg;
   localparam int CH_BITS      = 8;
   localparam int CH_COUNT     = 32;
   localparam int FRAMES       = 16;
   localparam logic [4:0] CH_MASTER_TWO = 5'h1F;  // stream a
   localparam logic [4:0] CH_SIG_CTRL   = 5'h0F;  // stream a, common mode
   localparam logic [4:0] CH_MF_WORD    = 5'h00;  // stream b
   localparam logic [4:0] CH_SIG_SLOT   = 5'h10;
   localparam int BIT_COMMON_SEL  = 5;
   localparam int BIT_RCLK_EN     = 4;
   localparam int BIT_ALL_ONES    = 3;
   localparam int BIT_SLOT_ONES   = 2;
   localparam int BIT_GEN_OUT     = 1;
   localparam logic [7:0] MASTER_TWO_RESET = 8'h80;
   localparam logic [7:0] MF_WORD_RESET    = 8'h0F;
   localparam logic [7:0] ALL_ONES         = 8'hFF;
   localparam logic [7:0] IDLE_SIG         = 8'hFF;
   localparam int CLK_MHZ        = 100;
   localparam int FRAME_RATE_KHZ = 8;
endpackage : emc_pkg

// >>> tb/emc_ctrl_chk.sv
// Purpose: port checks for emc_ctrl
// Assumes: one clock, BIT_STB held high
// Notes:   settings may only move with the last slot of a frame
`timescale 1ns/100ps
module emc_ctrl_chk (
   input wire logic       SYS_CLK,
   input wire logic       RST,
   input wire logic       RX_SLOT_VALID,
   input wire logic [4:0] RX_SLOT_NUM,
   input wire logic       RX_FRAME_LOCK,
   input wire logic       RX_FRAME_PULSE,
   input wire logic       TX_SLOT_VALID,
   input wire logic [4:0] TX_SLOT_NUM,
   input wire logic [3:0] TX_FRAME_NUM,
   input wire logic       SLOT16_RX_VALID,
   input wire logic       COMMON_MODE,
   input wire logic       SIG_CTRL_VALID,
   input wire logic       recovered_frame_clock_pin_o,
   input wire logic       recovered_frame_clock_pin_oe_n,
   input wire logic       general_output_pin
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence last_slot_s; TX_SLOT_VALID && TX_SLOT_NUM == 5'h1F; endsequence
   sequence rx_slot16_s; RX_SLOT_VALID && RX_SLOT_NUM == 5'h10; endsequence
   ctrl_mode_a: assert property (SIG_CTRL_VALID |-> COMMON_MODE) else $error("control word out of mode");
   rx16_mode_a: assert property (SLOT16_RX_VALID |-> COMMON_MODE) else $error("slot 16 out of mode");
   rx16_pass_a: assert property (rx_slot16_s ##0 COMMON_MODE |-> ##[1:8] SLOT16_RX_VALID) else $error("no slot 16");
   clk_off_a: assert property (!RX_FRAME_LOCK [*2] |-> !recovered_frame_clock_pin_o) else $error("clock unlocked");
   clk_rise_a: assert property (RX_FRAME_LOCK && RX_FRAME_PULSE ##1 RX_FRAME_LOCK |-> recovered_frame_clock_pin_o)
      else $error("clock not high");
   clk_fall_a: assert property (rx_slot16_s |=> !recovered_frame_clock_pin_o) else $error("clock not low");
   frame_step_a: assert property (last_slot_s ##8 TX_SLOT_VALID |-> TX_FRAME_NUM == $past(TX_FRAME_NUM, 9) + 4'h1)
      else $error("frame count");
   apply_edge_a: assert property ($changed({COMMON_MODE, general_output_pin, recovered_frame_clock_pin_oe_n})
      |-> last_slot_s) else $error("settings moved mid frame");
endmodule // emc_ctrl_chk

// >>> tb/emc_host.sv
// Purpose: host model sending control and data streams
// Assumes: one bit per cycle, frames back to back
// Notes:   arrays are snapshotted at frame start so the bench may refill them
`timescale 1ns/100ps
module emc_host (
   input  wire logic       SYS_CLK,
   input  wire logic       RST,
   input  wire logic [7:0] ch_a [32],
   input  wire logic [7:0] ch_b [32],
   input  wire logic [7:0] ch_d [32],
   output logic            bit_stb,
   output logic            frame_sync,
   output logic            stream_a,
   output logic            stream_b,
   output logic            data_in,
   output logic            frame_go
);
   logic [7:0] snap_a [32];
   logic [7:0] snap_b [32];
   logic [7:0] snap_d [32];
   logic [7:0] cnt;
   logic       rst_seen;
   initial {bit_stb, frame_sync, stream_a, stream_b, data_in, frame_go, cnt} = '0;
   always @(posedge SYS_CLK) begin
      rst_seen = RST;
      #1;
      if (rst_seen) begin
         cnt = 8'h00;
         bit_stb = 1'b0;
      end else begin
         if (cnt == 8'h00) begin
            snap_a = ch_a;
            snap_b = ch_b;
            snap_d = ch_d;
         end
         bit_stb = 1'b1;
         frame_sync = (cnt == 8'h00);
         frame_go = frame_sync;
         stream_a = snap_a[cnt[7:3]][3'h7 - cnt[2:0]];
         stream_b = snap_b[cnt[7:3]][3'h7 - cnt[2:0]];
         data_in = snap_d[cnt[7:3]][3'h7 - cnt[2:0]];
         cnt = cnt + 8'h01;
      end
   end
endmodule // emc_host

// >>> tb/emc_ctrl_bench.sv
// Purpose: self-checking bench for emc_ctrl
// Assumes: frames back to back, receive side offset from transmit
// Notes:   first multiframe unchecked while stored words settle
`timescale 1ns/100ps
module emc_ctrl_bench;
   import emc_pkg::*;
   logic sys_clk, rst, stb, fsync, sa, sb, sd, go, rx_valid, rx_lock, rx_pulse;
   logic tx_valid, s16_valid, cm, sc_valid, clk_o, clk_oe_n, gp;
   logic [7:0] rx_data, tx_data, s16_data, sc_word, rx16, rc, w_prev, v;
   logic [4:0] rx_num, tx_num;
   logic [3:0] tx_fn;
   logic [7:0] ch_a [32], ch_b [32], ch_d [32];
   logic [16:0] exp_q [$];
   logic [16:0] e;
   logic [31:0] seed;
   int err_count, checked, f, k;
   emc_ctrl u_dut (.SYS_CLK(sys_clk), .RST(rst), .BIT_STB(stb), .FRAME_SYNC(fsync), .control_in_stream_a(sa),
      .control_in_stream_b(sb), .serial_data_in_stream(sd), .RX_SLOT_DATA(rx_data), .RX_SLOT_VALID(rx_valid),
      .RX_SLOT_NUM(rx_num), .RX_FRAME_LOCK(rx_lock), .RX_FRAME_PULSE(rx_pulse), .TX_SLOT_DATA(tx_data),
      .TX_SLOT_VALID(tx_valid), .TX_SLOT_NUM(tx_num), .TX_FRAME_NUM(tx_fn), .SLOT16_RX_DATA(s16_data),
      .SLOT16_RX_VALID(s16_valid), .COMMON_MODE(cm), .SIG_CTRL_VALID(sc_valid), .SIG_CTRL_WORD(sc_word),
      .recovered_frame_clock_pin_o(clk_o), .recovered_frame_clock_pin_oe_n(clk_oe_n), .general_output_pin(gp));
   emc_host u_host (.SYS_CLK(sys_clk), .RST(rst), .ch_a(ch_a), .ch_b(ch_b), .ch_d(ch_d), .bit_stb(stb),
      .frame_sync(fsync), .stream_a(sa), .stream_b(sb), .data_in(sd), .frame_go(go));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] y);
      checked++;
      if (y !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, x, y);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin // receive framer side
      #1;
      rc = rst ? 8'h64 : rc + 8'h01;
      seed = xs(seed);
      rx_pulse = (rc == 8'h00);
      rx_valid = (rc[2:0] == 3'h7);
      rx_num = rc[7:3];
      rx_data = seed[7:0];
      if (rc == 8'h64) rx_lock = (f % 8 != 5);
      if (rx_valid && rx_num == CH_SIG_SLOT) rx16 = rx_data;
   end
   always @(posedge sys_clk) begin // result watcher
      #2;
      if (sc_valid === 1'b1) cmp("control word", 8'h5A, sc_word);
      if (s16_valid === 1'b1) cmp("rx slot 16", rx16, s16_data);
      if (tx_valid === 1'b1) begin
         if (exp_q.size() == 0) cmp("queued slot", 8'h01, 8'h00);
         else e = exp_q.pop_front();
         if (e[0]) begin
            cmp("slot number", {3'h0, e[16:12]}, {3'h0, tx_num});
            cmp("slot data", e[11:4], tx_data);
            if (e[16:12] != 5'h1F) cmp("pins", {5'h0, e[3:1]}, {5'h0, gp, clk_oe_n, cm});
         end
      end
   end
   initial begin
      {rst, rx_lock, rx_valid, rx_pulse, rx_num, rx_data, rc, e, f} = {3'h5, 39'h0, 32'h0};
      {err_count, checked, seed, w_prev} = {64'h0, 32'hC8062271, MASTER_TWO_RESET};
      for (k = 0; k < 32; k++) begin
         {ch_a[k], ch_d[k], ch_b[k]} = {16'h00FF, k[3:0], ~k[3:0]};
      end
      {ch_b[0], ch_a[15], ch_a[31]} = 24'h0B5A80;
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'b0;
      for (f = 0; f < 50; f++) begin
         k = 0;
         do begin
            @(posedge sys_clk);
            #2 k++;
         end while (go !== 1'b1 && k < 300);
         if (k >= 300) begin
            err_count++;
            $display("[ERR] frame start expected 1 seen 0");
            end_of_test();
         end
         for (k = 0; k < 32; k++) begin
            if (w_prev[BIT_ALL_ONES] || (k == 16 && w_prev[BIT_SLOT_ONES])) v = ALL_ONES;
            else if (k != 16 || w_prev[BIT_COMMON_SEL]) v = ch_d[k];
            else if (f % 16 == 0) v = ch_b[0];
            else v = {f[3:0], ~f[3:0]};
            exp_q.push_back({k[4:0], v, w_prev[BIT_GEN_OUT], ~w_prev[BIT_RCLK_EN], w_prev[BIT_COMMON_SEL], f > 15});
         end
         w_prev = ch_a[31];
         for (k = 0; k < 32; k++) begin
            seed = xs(seed);
            ch_d[k] = (k == 31) ? 8'hFF : seed[7:0];
            if (k > 0 && k < 16) ch_b[k] = w_prev[BIT_COMMON_SEL] ? seed[15:8] : {k[3:0], ~k[3:0]};
         end
         ch_a[31] = (f < 15 || f % 16 == 14) ? 8'h80 : 8'h80 | (seed[31:24] & 8'h3E);
      end
      repeat (20) @(posedge sys_clk);
      end_of_test();
   end
endmodule // emc_ctrl_bench
bind emc_ctrl emc_ctrl_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .RX_SLOT_VALID(RX_SLOT_VALID),
   .RX_SLOT_NUM(RX_SLOT_NUM), .RX_FRAME_LOCK(RX_FRAME_LOCK), .RX_FRAME_PULSE(RX_FRAME_PULSE),
   .TX_SLOT_VALID(TX_SLOT_VALID), .TX_SLOT_NUM(TX_SLOT_NUM), .TX_FRAME_NUM(TX_FRAME_NUM),
   .SLOT16_RX_VALID(SLOT16_RX_VALID), .COMMON_MODE(COMMON_MODE), .SIG_CTRL_VALID(SIG_CTRL_VALID),
   .recovered_frame_clock_pin_o(recovered_frame_clock_pin_o), .general_output_pin(general_output_pin),
   .recovered_frame_clock_pin_oe_n(recovered_frame_clock_pin_oe_n));
